// [rtl/rmih_device.sv]
// drive end: monitor refresh and instruction execution
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module rmih_device
  import rmih_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  rmih_if.device rb,
  input wire logic [31:0] mon_value [30],
  output logic [7:0] item_wr_index,
  output logic [15:0] item_wr_data,
  output logic item_wr_strobe
);
  logic mon_flag_q;
  logic [15:0] res_al_q, res_ah_q, res_bl_q, res_bh_q;
  logic [15:0] resp_q, rd_q;
  logic [15:0] items_q [RMIH_ITEMS];
  rmih_ist_t ist_q;
  logic [3:0] wcnt_q;
  logic cmpl_q;
  logic wr_go_q;
  logic [7:0] widx_q;
  logic [15:0] wdat_q;

  function automatic logic mon_ok(input logic [15:0] c);
    mon_ok = (c <= RMIH_MON_MAX);
  endfunction : mon_ok

  wire sel_ok = mon_ok(rb.monitor_select_a) && mon_ok(rb.monitor_select_b);
  wire [4:0] sa = rb.monitor_select_a[4:0];
  wire [4:0] sb = rb.monitor_select_b[4:0];
  wire [31:0] va = sel_ok ? mon_value[sa] : 32'h0000_0000;
  wire [31:0] vb = sel_ok ? mon_value[sb] : 32'h0000_0000;
  // a quantity with no upper half is the sign-extended low word
  wire [15:0] va_hi = va[31:16];
  wire [15:0] vb_hi = vb[31:16];
  wire [15:0] code = rb.instruction_word;
  wire is_rd = (code <= RMIH_RD_MAX);
  wire is_wr = (code >= RMIH_WR_MIN) && (code <= RMIH_WR_MAX);
  wire [7:0] idx = code[7:0];
  wire rd_noref = (idx >= RMIH_NOREF_BASE);
  wire wr_range = (rb.write_data_word > RMIH_WR_LIMIT);
  wire new_req = rb.instruction_request && (ist_q == RMIH_I_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_flag_q <= 1'b0;
      res_al_q <= 16'h0000;
      res_ah_q <= 16'h0000;
      res_bl_q <= 16'h0000;
      res_bh_q <= 16'h0000;
    end else begin
      mon_flag_q <= rb.monitor_request; // [RQ2] [RQ21]
      if (rb.monitor_request) begin // [RQ4] [RQ9]
        if (rb.two_station) begin
          res_al_q <= va[15:0]; // [RQ7]
          res_ah_q <= va_hi; // [RQ8]
          res_bl_q <= vb[15:0];
          res_bh_q <= vb_hi;
        end else begin
          res_al_q <= va[15:0];
          res_ah_q <= vb[15:0];
          res_bl_q <= 16'h0000;
          res_bh_q <= 16'h0000;
        end
      end // else hold [RQ5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= RMIH_I_IDLE;
      cmpl_q <= 1'b0;
      rd_q <= 16'h0000;
      resp_q <= 16'h0000;
      wcnt_q <= 4'h0;
      wr_go_q <= 1'b0;
      widx_q <= 8'h00;
      wdat_q <= 16'h0000;
    end else begin
      wr_go_q <= 1'b0;
      if (rb.monitor_request && !mon_flag_q) begin
        resp_q <= sel_ok ? RMIH_RESP_OK : RMIH_RESP_CODE; // [RQ6] [RQ19]
      end
      unique case (ist_q)
        RMIH_I_IDLE: begin
          if (new_req) begin
            if (is_rd) begin
              ist_q <= RMIH_I_DONE;
              cmpl_q <= 1'b1; // [RQ11]
              if (rd_noref) begin
                resp_q <= RMIH_RESP_NOREF; // [RQ13] [RQ20]
              end else begin
                rd_q <= items_q[idx]; // [RQ11] [RQ12]
                resp_q <= RMIH_RESP_OK;
              end
            end else if (is_wr && !wr_range) begin
              ist_q <= RMIH_I_WRITE;
              wcnt_q <= RMIH_WR_CYCLES;
              widx_q <= idx;
              wdat_q <= rb.write_data_word;
            end else begin
              ist_q <= RMIH_I_DONE;
              cmpl_q <= 1'b1;
              // [RQ17] [RQ20]
              resp_q <= is_wr ? RMIH_RESP_RANGE : RMIH_RESP_CODE;
            end
          end
        end
        RMIH_I_WRITE: begin
          // completion only after the item has been updated
          if (wcnt_q == 4'h1) begin
            wr_go_q <= 1'b1;
          end
          if (wcnt_q == 4'h0) begin
            ist_q <= RMIH_I_DONE;
            cmpl_q <= 1'b1; // [RQ16]
            resp_q <= RMIH_RESP_OK;
          end else begin
            wcnt_q <= wcnt_q - 4'h1;
          end
        end
        RMIH_I_DONE: begin
          if (!rb.instruction_request) begin
            ist_q <= RMIH_I_IDLE;
            cmpl_q <= 1'b0; // [RQ21]
          end
        end
      endcase
    end
  end

  // item store has no reset: contents are data, not control
  always_ff @(posedge aclk) begin
    if (wr_go_q) begin
      items_q[widx_q] <= wdat_q; // [RQ16]
    end
  end

  assign rb.monitoring_flag = mon_flag_q;
  assign rb.monitor_result_a_low = res_al_q;
  assign rb.monitor_result_a_high = res_ah_q;
  assign rb.monitor_result_b_low = res_bl_q;
  assign rb.monitor_result_b_high = res_bh_q;
  assign rb.response_code_word = resp_q;
  assign rb.read_result_word = rd_q;
  assign rb.instruction_completion = cmpl_q;
  assign item_wr_index = widx_q;
  assign item_wr_data = wdat_q;
  assign item_wr_strobe = wr_go_q;
endmodule : rmih_device

// [rtl/rmih_pkg.sv]
// shared constants and types for the remote monitor / instruction handshake
// Functional notes
// (RQ1) master loads codes 0000-001D, raises monitor_request
// (RQ2) device fills results, raises monitoring_flag together
// (RQ3) 32-bit one-station: low code a, high b
// (RQ4) one-station results refresh while request held
// (RQ5) flag low freezes monitor result words
// (RQ6) bad monitor code gives response code 1
// (RQ7) two-station splits each value, four words
// (RQ8) missing upper half filled with sign
// (RQ9) two-station words refresh while flag high
// (RQ10) master issues read code 0000h-0A1Fh, requests
// (RQ11) read result and completion appear together
// (RQ12) result held until next read request
// (RQ13) bad read code or item reports error
// (RQ14) master drops request after capturing result
// (RQ15) master issues write code 8000h-911Fh plus data
// (RQ16) completion rises only after write applied
// (RQ17) unsupported write code reports error value
// (RQ18) master drops request after write completion
// (RQ19) response code zero on normal completion
// (RQ20) code 2 unreadable item, 3 range error
// (RQ21) device drops flag after request drops
package rmih_pkg;
  localparam logic [15:0] RMIH_MON_MAX = 16'h001D;
  localparam logic [15:0] RMIH_RD_MAX = 16'h0A1F;
  localparam logic [15:0] RMIH_WR_MIN = 16'h8000;
  localparam logic [15:0] RMIH_WR_MAX = 16'h911F;
  localparam logic [15:0] RMIH_RESP_OK = 16'h0000;
  localparam logic [15:0] RMIH_RESP_CODE = 16'h0001;
  localparam logic [15:0] RMIH_RESP_NOREF = 16'h0002;
  localparam logic [15:0] RMIH_RESP_RANGE = 16'h0003;
  localparam logic [15:0] RMIH_SIGN_POS = 16'h0000;
  localparam logic [15:0] RMIH_SIGN_NEG = 16'hFFFF;
  // item table: 256 words addressed by the low byte of the code
  localparam int RMIH_ITEMS = 256;
  // items at or above this index may be written but not read back
  localparam logic [7:0] RMIH_NOREF_BASE = 8'hF0;
  // writes above this value are out of range
  localparam logic [15:0] RMIH_WR_LIMIT = 16'h7FFF;
  // write countdown load; completion rises one cycle after it reaches zero
  localparam logic [3:0] RMIH_WR_CYCLES = 4'h3;
  // AXI4-Lite register offsets of the host controller
  localparam logic [5:0] RMIH_A_CTRL = 6'h00;
  localparam logic [5:0] RMIH_A_MSEL = 6'h04;
  localparam logic [5:0] RMIH_A_INSTR = 6'h08;
  localparam logic [5:0] RMIH_A_WDATA = 6'h0C;
  localparam logic [5:0] RMIH_A_STAT = 6'h10;
  localparam logic [5:0] RMIH_A_MRES_A = 6'h14;
  localparam logic [5:0] RMIH_A_MRES_B = 6'h18;
  localparam logic [5:0] RMIH_A_RDRES = 6'h1C;
  localparam logic [5:0] RMIH_A_RESP = 6'h20;
  // control register bits
  localparam int RMIH_C_MON = 0;
  localparam int RMIH_C_INS = 1;
  localparam int RMIH_C_TWO = 2;
  localparam logic [1:0] RMIH_AXI_OKAY = 2'h0;
  localparam logic [1:0] RMIH_AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {RMIH_I_IDLE, RMIH_I_WRITE, RMIH_I_DONE} rmih_ist_t;
endpackage : rmih_pkg

// [rtl/rmih_if.sv]
// remote bits and words between fieldbus master and drive
`timescale 1ns/1ps
interface rmih_if;
  logic two_station;
  logic [15:0] monitor_select_a;
  logic [15:0] monitor_select_b;
  logic monitor_request;
  logic monitoring_flag;
  logic [15:0] monitor_result_a_low;
  logic [15:0] monitor_result_a_high;
  logic [15:0] monitor_result_b_low;
  logic [15:0] monitor_result_b_high;
  logic [15:0] response_code_word;
  logic [15:0] instruction_word;
  logic [15:0] write_data_word;
  logic [15:0] read_result_word;
  logic instruction_request;
  logic instruction_completion;
  modport device (
    input two_station, monitor_select_a, monitor_select_b, monitor_request,
    input instruction_word, write_data_word, instruction_request,
    output monitoring_flag, monitor_result_a_low, monitor_result_a_high,
    output monitor_result_b_low, monitor_result_b_high, response_code_word,
    output read_result_word, instruction_completion
  );
  modport master (
    output two_station, monitor_select_a, monitor_select_b, monitor_request,
    output instruction_word, write_data_word, instruction_request,
    input monitoring_flag, monitor_result_a_low, monitor_result_a_high,
    input monitor_result_b_low, monitor_result_b_high, response_code_word,
    input read_result_word, instruction_completion
  );
endinterface : rmih_if

// [rtl/rmih_master.sv]
// controller end: AXI4-Lite registers drive the remote bits and words
`timescale 1ns/1ps
module rmih_master
  import rmih_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  rmih_if.master rb,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [2:0] ctrl_q;
  logic [31:0] msel_q;
  logic [15:0] instr_q, wdata_q;
  logic [5:0] awa_q;
  logic aw_q, w_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // remote inputs come from the device's own flops
  wire do_wr = aw_q && w_q && !bvalid_q;
  wire wr_hit = (awa_q == RMIH_A_CTRL) || (awa_q == RMIH_A_MSEL) ||
                (awa_q == RMIH_A_INSTR) || (awa_q == RMIH_A_WDATA);

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction : merge

  wire [31:0] ctrl_m = merge({29'h0, ctrl_q}, wd_q, ws_q);
  wire [31:0] instr_m = merge({16'h0, instr_q}, wd_q, ws_q);
  wire [31:0] wdat_m = merge({16'h0, wdata_q}, wd_q, ws_q);
  // handshake bits the device raises: read back in status
  wire [31:0] stat = {29'h0, rb.instruction_completion, rb.monitoring_flag,
                      1'b0};
  logic [31:0] rmux;
  logic rhit;
  always_comb begin
    rhit = 1'b1;
    unique case (s_axi_araddr)
      RMIH_A_CTRL: rmux = {29'h0, ctrl_q};
      RMIH_A_MSEL: rmux = msel_q;
      RMIH_A_INSTR: rmux = {16'h0, instr_q};
      RMIH_A_WDATA: rmux = {16'h0, wdata_q};
      RMIH_A_STAT: rmux = stat;
      RMIH_A_MRES_A: rmux = {rb.monitor_result_a_high, rb.monitor_result_a_low};
      RMIH_A_MRES_B: rmux = {rb.monitor_result_b_high, rb.monitor_result_b_low};
      RMIH_A_RDRES: rmux = {16'h0, rb.read_result_word};
      RMIH_A_RESP: rmux = {16'h0, rb.response_code_word};
      default: begin
        rmux = 32'h0000_0000;
        rhit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 6'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RMIH_AXI_OKAY;
      ctrl_q <= 3'h0;
      msel_q <= 32'h0000_0000;
      instr_q <= 16'h0000;
      wdata_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RMIH_AXI_OKAY : RMIH_AXI_SLVERR;
        // selects and data are loaded before software raises the request
        unique case (awa_q)
          RMIH_A_CTRL: ctrl_q <= ctrl_m[2:0]; // [RQ1] [RQ10] [RQ14] [RQ18]
          RMIH_A_MSEL: msel_q <= merge(msel_q, wd_q, ws_q); // [RQ3]
          RMIH_A_INSTR: instr_q <= instr_m[15:0]; // [RQ10] [RQ15]
          RMIH_A_WDATA: wdata_q <= wdat_m[15:0]; // [RQ15]
          default: ;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RMIH_AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rmux; // [RQ12]
      rresp_q <= rhit ? RMIH_AXI_OKAY : RMIH_AXI_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rb.monitor_request = ctrl_q[RMIH_C_MON];
  assign rb.instruction_request = ctrl_q[RMIH_C_INS];
  assign rb.two_station = ctrl_q[RMIH_C_TWO];
  assign rb.monitor_select_a = msel_q[15:0];
  assign rb.monitor_select_b = msel_q[31:16];
  assign rb.instruction_word = instr_q;
  assign rb.write_data_word = wdata_q;
endmodule : rmih_master

// [verification/rmih_props.sv]
// concurrent checks on the remote bits and words joining the two ends
`timescale 1ns/1ps
module rmih_props
  import rmih_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic monitor_request,
  input wire logic monitoring_flag,
  input wire logic [15:0] monitor_select_a,
  input wire logic [15:0] monitor_select_b,
  input wire logic [15:0] monitor_result_a_low,
  input wire logic [15:0] monitor_result_a_high,
  input wire logic [15:0] monitor_result_b_low,
  input wire logic [15:0] monitor_result_b_high,
  input wire logic [15:0] response_code_word,
  input wire logic [15:0] instruction_word,
  input wire logic [15:0] write_data_word,
  input wire logic [15:0] read_result_word,
  input wire logic instruction_request,
  input wire logic instruction_completion
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire mon_ok = monitor_select_a <= RMIH_MON_MAX &&
    monitor_select_b <= RMIH_MON_MAX;
  wire rd = instruction_word <= RMIH_RD_MAX;
  wire wr = instruction_word >= RMIH_WR_MIN && instruction_word <= RMIH_WR_MAX;
  wire fit = write_data_word <= RMIH_WR_LIMIT;
  wire [15:0] rd_resp = instruction_word[7:0] >= RMIH_NOREF_BASE ?
    RMIH_RESP_NOREF : RMIH_RESP_OK;
  wire [63:0] res = {monitor_result_a_low, monitor_result_a_high,
    monitor_result_b_low, monitor_result_b_high};
  wire [15:0] rc = response_code_word;
  wire done = instruction_completion;
  AST_FLAG_ON: assert property (monitor_request |=> monitoring_flag)
    else $error("monitoring flag did not follow request");
  AST_FLAG_OFF: assert property (!monitor_request |=> !monitoring_flag)
    else $error("monitoring flag stayed after request dropped");
  AST_MON_HOLD: assert property (!monitor_request |=> $stable(res))
    else $error("monitor results moved while not requested");
  AST_MON_ERR: assert property ($rose(monitor_request) && !mon_ok |=>
    rc == RMIH_RESP_CODE) else $error("bad monitor code not reported");
  AST_MON_OK: assert property ($rose(monitor_request) && mon_ok |=>
    rc == RMIH_RESP_OK) else $error("good monitor code not answered zero");
  AST_RD_DONE: assert property ($rose(instruction_request) && rd |=>
    done && rc == rd_resp) else $error("read answer wrong or late");
  AST_WR_LATE: assert property ($rose(instruction_request) && wr && fit |=>
    !done [*4] ##1 (done && rc == RMIH_RESP_OK))
    else $error("write completion timing wrong");
  AST_WR_RANGE: assert property ($rose(instruction_request) && wr && !fit |=>
    done && rc == RMIH_RESP_RANGE) else $error("range error not reported");
  AST_BAD_CODE: assert property ($rose(instruction_request) && !rd && !wr |=>
    done && rc == RMIH_RESP_CODE) else $error("bad instruction not reported");
  AST_RD_HOLD: assert property (!$rose(instruction_request) |=>
    $stable(read_result_word)) else $error("read result not held");
  AST_DONE_DROP: assert property ($fell(instruction_request) |=> !done)
    else $error("completion stayed after request dropped");
  cover property ($rose(monitoring_flag));
  cover property ($rose(done) && wr);
  cover property (rc == RMIH_RESP_NOREF);
endmodule : rmih_props

// [verification/tb_remote_monitor_instruction_handshake.sv]
// bench: both ends joined, driven over AXI4-Lite, checked against a model
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_remote_monitor_instruction_handshake
  import rmih_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [31:0] wdata = '0, rdata, rv;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] mon [30];
  logic [15:0] item [256];
  logic [15:0] rdq = '0;
  logic [15:0] tc [11] = '{16'h911F, 16'h8000, 16'h0A1F, 16'h0000, 16'h05F3,
    16'h8E10, 16'h0A20, 16'h7FFF, 16'h9120, 16'hFFFF, 16'h80F5};
  int num_errors = 0, cmp_count = 0;
  logic wstb;
  logic [7:0] widx;
  logic [15:0] wdat;
  logic [23:0] wr_last = '0, wexp = '0;
  int wr_seen = 0;
  always #10 aclk = ~aclk;
  // every item write pulse is logged so the model can count them
  always @(posedge aclk) begin
    if (wstb === 1'h1) begin
      wr_seen <= wr_seen + 1;
      wr_last <= {widx, wdat};
    end
  end
  rmih_if rb ();
  rmih_device i_rmih_device (.aclk(aclk), .aresetn(aresetn), .rb(rb.device),
    .mon_value(mon), .item_wr_index(widx), .item_wr_data(wdat),
    .item_wr_strobe(wstb));
  rmih_master i_rmih_master (.aclk(aclk), .aresetn(aresetn), .rb(rb.master),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rmih_props i_rmih_props (.aclk(aclk), .aresetn(aresetn),
    .monitor_request(rb.monitor_request), .monitoring_flag(rb.monitoring_flag),
    .monitor_select_a(rb.monitor_select_a),
    .monitor_select_b(rb.monitor_select_b),
    .monitor_result_a_low(rb.monitor_result_a_low),
    .monitor_result_a_high(rb.monitor_result_a_high),
    .monitor_result_b_low(rb.monitor_result_b_low),
    .monitor_result_b_high(rb.monitor_result_b_high),
    .response_code_word(rb.response_code_word),
    .instruction_word(rb.instruction_word),
    .write_data_word(rb.write_data_word),
    .read_result_word(rb.read_result_word),
    .instruction_request(rb.instruction_request),
    .instruction_completion(rb.instruction_completion));
  // leading edge keeps a new request off the edge that ended the last one
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge aclk);
    rv = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : axr
  task automatic poll(input int b, input logic v);
    do axr(RMIH_A_STAT); while (rv[b] !== v);
  endtask : poll
  // even codes carry no upper half, so their top word is pure sign
  task automatic shuffle();
    logic [31:0] x;
    for (int i = 0; i < 30; i++) begin
      x = $urandom;
      mon[i] <= i[0] ? x : {{16{x[15]}}, x[15:0]};
    end
  endtask : shuffle
  task automatic mt(input logic ts, input logic [15:0] sa, sb);
    logic [31:0] ea, eb;
    logic bad;
    bad = sa > RMIH_MON_MAX || sb > RMIH_MON_MAX;
    axw(RMIH_A_MSEL, {sb, sa});
    axw(RMIH_A_CTRL, {29'h0, ts, 2'h1});
    poll(1, 1'h1);
    axr(RMIH_A_RESP);
    `CHK("monitor response", {31'h0, bad}, rv)
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        axw(RMIH_A_CTRL, 32'h0);
        poll(1, 1'h0);
      end
      shuffle();
      repeat (3) @(posedge aclk);
      if (k < 2) begin
        ea = ts ? mon[sa] : {mon[sb][15:0], mon[sa][15:0]};
        eb = ts ? mon[sb] : 32'h0;
      end
      if (!bad) begin
        axr(RMIH_A_MRES_A);
        `CHK("result a", ea, rv)
        axr(RMIH_A_MRES_B);
        `CHK("result b", eb, rv)
      end
    end
  endtask : mt
  task automatic ins(input logic [15:0] c, d);
    logic [15:0] er;
    int ws;
    ws = wr_seen;
    axw(RMIH_A_INSTR, {16'h0, c});
    axw(RMIH_A_WDATA, {16'h0, d});
    axw(RMIH_A_CTRL, 32'h2);
    poll(2, 1'h1);
    er = RMIH_RESP_CODE;
    if (c <= RMIH_RD_MAX) begin
      er = c[7:0] >= RMIH_NOREF_BASE ? RMIH_RESP_NOREF : RMIH_RESP_OK;
      if (er == RMIH_RESP_OK) rdq = item[c[7:0]];
    end else if (c >= RMIH_WR_MIN && c <= RMIH_WR_MAX) begin
      er = d > RMIH_WR_LIMIT ? RMIH_RESP_RANGE : RMIH_RESP_OK;
      if (er == RMIH_RESP_OK) begin
        item[c[7:0]] = d;
        wexp = {c[7:0], d};
        ws++;
      end
    end
    axr(RMIH_A_RESP);
    `CHK("instr response", {16'h0, er}, rv)
    axr(RMIH_A_RDRES);
    `CHK("read result", {16'h0, rdq}, rv)
    `CHK("item writes", ws, wr_seen)
    `CHK("item written", wexp, wr_last)
    axw(RMIH_A_CTRL, 32'h0);
    poll(2, 1'h0);
  endtask : ins
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    #(20 * 40000);
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [7:0] ix;
    void'($urandom(32'hBD28640B));
    shuffle();
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axw(6'h24, 32'h0);
    `CHK("write resp", RMIH_AXI_SLVERR, rs)
    axr(6'h3C);
    `CHK("read resp", RMIH_AXI_SLVERR, rs)
    $display("test bus done");
    for (int t = 0; t < 2; t++) begin
      mt(t[0], 16'h0, RMIH_MON_MAX);
      mt(t[0], 16'h1E, 16'h3);
      mt(t[0], 16'($urandom_range(0, 29)), 16'($urandom_range(0, 29)));
      mt(t[0], 16'h4, 16'hFFFF);
    end
    $display("test monitor done");
    foreach (tc[i])
      ins(tc[i], tc[i] == 16'h8E10 ? 16'h8001 : 16'($urandom_range(0, 'h7FFF)));
    repeat (6) begin
      ix = 8'($urandom_range(0, 'hEF));
      // stay below 91xx so the item read back next has surely been written
      ins({8'($urandom_range('h80, 'h90)), ix}, 16'($urandom_range(0, 'h7FFF)));
      ins({8'($urandom_range(0, 9)), ix}, 16'h0);
    end
    $display("test instruction done");
    wrap_up();
  end
endmodule : tb_remote_monitor_instruction_handshake
